// *** irq_arb_assertions.sv ***
// concurrent checks on the arbiter's ports
`default_nettype none
module irq_arb_checker (
	input wire logic        hclk,         // clock
	input wire logic        hresetn,      // reset, low
	input wire logic        hreadyout,    // bus ready
	input wire logic        hresp,        // bus response
	input wire logic        instr_start,  // boundary
	input wire logic        skip_pending, // skip
	input wire logic        boot_rom_exec,// boot rom
	input wire logic        vis_start,    // vector select
	input wire logic [14:0] vis_pc,       // select address
	input wire logic [14:0] next_pc,      // return address
	input wire logic        return_from_irq_instr_exec,    // return
	input wire logic [14:0] pop_addr,     // popped address
	input wire logic        ack_busy,     // ack running
	input wire logic        push_strobe,  // push
	input wire logic [14:0] push_addr,    // pushed address
	input wire logic        pc_load,      // pc load
	input wire logic [14:0] pc_value,     // new pc
	input wire logic        pmem_rd,      // memory read
	input wire logic [14:0] pmem_addr,    // memory address
	input wire logic        global_irq_enable_o // global enable
);
	logic [14:0] vis_pc_q;
	always_ff @(posedge hclk) begin
		vis_pc_q <= vis_pc;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence vis_req;
		vis_start && !ack_busy && !instr_start && !pmem_rd && !pc_load;
	endsequence
	sequence vis_fetch;
		##1 pmem_rd && pmem_addr[7:5] == 3'h7 && !pmem_addr[0]
		##1 pmem_rd && pmem_addr == $past(pmem_addr) + 15'h1 ##1 pc_load;
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
	chk_ack_entry: assert property (push_strobe |-> ##6 (pc_load && pc_value == 15'h00FF))
		else $error("entry jump missing");
	chk_busy_len: assert property ($rose(ack_busy) |-> ack_busy [*6] ##1 !ack_busy)
		else $error("ack length wrong");
	chk_ack_gie: assert property (push_strobe |-> !global_irq_enable_o)
		else $error("global enable kept on ack");
	chk_ack_cause: assert property (push_strobe |->
		$past(instr_start && !skip_pending && !boot_rom_exec && global_irq_enable_o))
		else $error("ack without cause");
	chk_push_addr: assert property (push_strobe |-> push_addr == $past(next_pc))
		else $error("wrong return address");
	chk_return_from_irq_instr_pop: assert property (return_from_irq_instr_exec && !ack_busy && !instr_start |=>
		pc_load && pc_value == $past(pop_addr) && global_irq_enable_o) else $error("bad return");
	chk_vis_seq: assert property (vis_req |-> vis_fetch)
		else $error("vector fetch order wrong");
	chk_vis_block: assert property (vis_req |=> pmem_addr[14:8] ==
		(vis_pc_q[7:0] == 8'hFF ? vis_pc_q[14:8] + 7'h1 : vis_pc_q[14:8]))
		else $error("vector table block wrong");
endmodule : irq_arb_checker
bind vectored_interrupt_arbiter irq_arb_checker chk_i (.hclk, .hresetn, .hreadyout, .hresp,
	.instr_start, .skip_pending, .boot_rom_exec, .vis_start, .vis_pc, .next_pc, .return_from_irq_instr_exec,
	.pop_addr, .ack_busy, .push_strobe, .push_addr, .pc_load, .pc_value, .pmem_rd,
	.pmem_addr, .global_irq_enable_o);
`default_nettype wire

// *** irq_arb_consts.svh ***
// constants for the vectored interrupt arbiter
// Summary of operation
// R1 - every acknowledge branches to entry 00FF
// R2 - trap is non-maskable, highest rank; others maskable
// R3 - pending and enable bits are software mapped
// R4 - maskable needs pending, enable, global, no trap
// R5 - qualify only at instruction start boundary
// R6 - highest fixed rank wins, others stay pending
// R7 - reset clears pending, enables, global enable
// R8 - enabling with pending set interrupts at once
// R9 - acknowledge clears global, pushes return, jumps
// R10 - acknowledge sequence lasts seven instruction cycles
// R11 - status write may set global enable
// R12 - return instruction sets global, pops address
// R13 - pending work acknowledged right after return
// R14 - routines clear their pending flag early
// R15 - boot ROM execution blocks interrupts, keeps global
// R16 - vector select jumps via highest active entry
// R17 - table at top of block, next if last
// R18 - vector is 15 bits, high byte first
// R19 - lowest rank at E0, trap at FE
// R20 - nothing active selects default vector E0
// R21 - sample first cycle, replace low PC byte
// R22 - trap fetch sets hidden flag, clear instruction
// R23 - synchronise peripheral events before pending flags
`ifndef IRQ_ARB_CONSTS_SVH
`define IRQ_ARB_CONSTS_SVH

`define IRQ_ENTRY_ADDR    15'h00FF
`define IRQ_ACK_CYCLES    3'h7
`define IRQ_TBL_BASE      8'hE0
`define IRQ_NSRC          16
`define IRQ_REG_PEND      12'h000
`define IRQ_REG_ENA       12'h004
`define IRQ_REG_PSR       12'h008
`define IRQ_REG_STAT      12'h00C
`define IRQ_PSR_GIE_BIT   0
`define IRQ_RESET_VAL     16'h0000

`endif

// *** irq_arb_pkg.sv ***
// types shared by the interrupt arbiter
`default_nettype none
package irq_arb_pkg;
	typedef enum logic [3:0] {
		ST_RUN  = 4'b0001,
		ST_ACK  = 4'b0010,
		ST_VIS  = 4'b0100,
		ST_VIS2 = 4'b1000
	} seq_state_t;
endpackage : irq_arb_pkg
`default_nettype wire

// *** irq_event_sync.sv ***
// two-stage synchroniser with rising-edge pulse for peripheral events
`default_nettype none
module irq_event_sync (
	input  wire logic        hclk,     // clock
	input  wire logic        hresetn,  // async reset, active low
	input  wire logic [15:0] ev_async, // raw event levels
	output logic      [15:0] ev_pulse  // one-cycle rising edge pulses
);
	logic [15:0] s1_r;
	logic [15:0] s2_r;
	logic [15:0] s3_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
			s3_r <= 16'h0000;
		end else begin
			s1_r <= ev_async;   // [R23]
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign ev_pulse = s2_r & ~s3_r;
endmodule : irq_event_sync
`default_nettype wire

// *** pmem_model.sv ***
// program memory model answering the arbiter's vector reads
`default_nettype none
module pmem_model (
	input  wire logic        hclk,      // clock
	input  wire logic        pmem_rd,   // read strobe
	input  wire logic [14:0] pmem_addr, // byte address
	output logic      [7:0]  pmem_rdata // byte, valid while the read strobe stands
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] idle_r = 8'hA5;
	// idle cycles toggle so a stale byte is never taken for data
	always @(posedge hclk) begin
		idle_r <= ~idle_r;
	end
	// asynchronous read: the arbiter takes the byte in the cycle of its strobe
	// block bits folded in so a wrong table block shows up in the vector
	assign pmem_rdata = pmem_rd ? (pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]}) : idle_r;
endmodule : pmem_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the vectored interrupt arbiter
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, global_irq_enable;
	logic        instr_start, skip_pending, boot_rom_exec, trap_fetch, trap_clear;
	logic        vis_start, return_from_irq_instr_exec, ack_busy, push_strobe, pc_load, pmem_rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [15:0] irq_events;
	logic [14:0] vis_pc, next_pc, pop_addr, push_addr, pc_value, pmem_addr, exp_pc;
	logic [7:0]  pmem_rdata;
	int          fail_count, n_tests, cyc, pend, ena, k;
	bit          trap;
	assign hready = hreadyout;
	vectored_interrupt_arbiter dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq_events, .instr_start, .skip_pending,
		.boot_rom_exec, .trap_fetch, .trap_clear, .vis_start, .vis_pc, .next_pc, .return_from_irq_instr_exec,
		.pop_addr, .pmem_rdata, .ack_busy, .push_strobe, .push_addr, .pc_load, .pc_value,
		.pmem_rd, .pmem_addr, .global_irq_enable_o(global_irq_enable));
	pmem_model mem (.hclk, .pmem_rd, .pmem_addr, .pmem_rdata);
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_sim();
		end
	end
	// ****************
	// tasks
	// ****************
	task clk(input int n);
		repeat (n) @(posedge hclk);
	endtask : clk
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp
	task end_sim();
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 20'h0, a, w, 3'h2};
		do clk(1); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do clk(1); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task pulse(input bit clr);
		{trap_clear, trap_fetch} <= {clr, !clr};
		clk(1);
		{trap_clear, trap_fetch} <= 2'h0;
		clk(1);
	endtask : pulse
	task ack_try(input bit e);
		logic got;
		next_pc <= 15'($urandom);
		instr_start <= 1'b1;
		clk(1);
		instr_start <= 1'b0;
		got = 1'b0;
		for (int i = 0; i < 3 && !got; i++) begin
			clk(1);
			got = (push_strobe === 1'b1);
		end
		cmp("ack", 32'(e), 32'(got));
		if (got) begin
			cmp("push_addr", 32'(next_pc), 32'(push_addr));
			clk(6);
			cmp("entry", 32'h80FF, {16'h0, pc_load, pc_value});
		end
	endtask : ack_try
	task vector_select_instr(input logic [14:0] pc);
		logic [14:0] a;
		k = trap ? 15 : 0;
		for (int i = 1; i < 15 && !trap; i++) if (pend[i] && ena[i]) k = i;
		a = {pc[7:0] == 8'hFF ? pc[14:8] + 7'h1 : pc[14:8], 8'hE0 + 8'(2 * k)};
		// memory byte = low address byte xor block, high byte at the even address
		exp_pc = {a[6:0] ^ a[14:8], {a[7:1], 1'b1} ^ {1'b0, a[14:8]}};
		{vis_pc, vis_start} <= {pc, 1'b1};
		clk(1);
		vis_start <= 1'b0;
		for (int i = 0; i < 5 && pc_load !== 1'b1; i++) clk(1);
		cmp("vis", {16'h0, 1'b1, exp_pc}, {16'h0, pc_load, pc_value});
	endtask : vector_select_instr
	// ****************
	// main sequence
	// ****************
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata, irq_events, instr_start} = '0;
		{skip_pending, boot_rom_exec, trap_fetch, trap_clear, vis_start, return_from_irq_instr_exec} = '0;
		{vis_pc, next_pc, pop_addr, hresetn, trap} = '0;
		void'($urandom(32'h6d35719a));
		clk(8);
		hresetn <= 1'b1;
		clk(1);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 12'(4 * i), 32'h0);
			cmp("reset", i == 3 ? 32'({irq_arb_pkg::ST_RUN, 2'b00}) : 32'h0, q);
		end
		for (int t = 0; t < 12; t++) begin
			bus(1'b1, 12'h004, 32'h0);
			bus(1'b1, 12'h000, 32'h0);
			pend = $urandom & 32'h7FFE;
			irq_events <= 16'(pend);
			clk(4);
			irq_events <= 16'h0;
			clk(4);
			bus(1'b0, 12'h000, 32'h0);
			cmp("pend", pend, q);
			ena = (t == 0) ? 0 : $urandom & 32'h7FFE;
			bus(1'b1, 12'h004, ena);
			bus(1'b0, 12'h004, 32'h0);
			cmp("ena", ena, q);
			trap = (t == 3);
			if (trap) pulse(1'b0);
			vector_select_instr(t == 1 ? {7'($urandom), 8'hFF} : 15'($urandom));
			if (trap) pulse(1'b1);
			trap = 1'b0;
		end
		bus(1'b1, 12'h004, 32'h0);
		bus(1'b1, 12'h008, 32'h1);
		ack_try(1'b0);
		bus(1'b1, 12'h000, 32'h2);
		bus(1'b1, 12'h004, 32'h2);
		ack_try(1'b1);
		bus(1'b0, 12'h008, 32'h0);
		cmp("gie", 32'h0, q);
		ack_try(1'b0);
		pop_addr <= 15'($urandom);
		return_from_irq_instr_exec <= 1'b1;
		clk(1);
		return_from_irq_instr_exec <= 1'b0;
		clk(1);
		cmp("return_from_irq_instr", {15'h0, 2'b11, pop_addr}, {15'h0, pc_load, global_irq_enable, pc_value});
		skip_pending <= 1'b1;
		ack_try(1'b0);
		{skip_pending, boot_rom_exec} <= 2'b01;
		ack_try(1'b0);
		boot_rom_exec <= 1'b0;
		pulse(1'b0);
		ack_try(1'b0);
		pulse(1'b1);
		bus(1'b0, 12'h008, 32'h0);
		cmp("gie", 32'h1, q);
		ack_try(1'b1);
		bus(1'b1, 12'h008, 32'h1);
		ack_try(1'b1);
		end_sim();
	end
endmodule : tb
`default_nettype wire

// *** vectored_interrupt_arbiter.sv ***
// interrupt qualification, acknowledge sequencing and vector selection
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`include "irq_arb_consts.svh"
`default_nettype none
module vectored_interrupt_arbiter (
	input  wire logic        hclk,           // instruction clock
	input  wire logic        hresetn,        // async reset, active low
	input  wire logic        hsel,           // ahb slave select
	input  wire logic [31:0] haddr,          // ahb address
	input  wire logic [1:0]  htrans,         // ahb transfer type
	input  wire logic        hwrite,         // ahb write
	input  wire logic [2:0]  hsize,          // ahb size
	input  wire logic [31:0] hwdata,         // ahb write data
	input  wire logic        hready,         // ahb bus ready
	output logic      [31:0] hrdata,         // ahb read data
	output logic             hreadyout,      // ahb slave ready
	output logic             hresp,          // ahb response, always okay
	input  wire logic [15:0] irq_events,     // async peripheral events, bit = rank slot
	input  wire logic        instr_start,    // core at a normal instruction boundary
	input  wire logic        skip_pending,   // next instruction is being skipped
	input  wire logic        boot_rom_exec,  // executing boot rom
	input  wire logic        trap_fetch,     // trap_opcode fetched
	input  wire logic        trap_clear,     // trap_flag_clear_instr executed
	input  wire logic        vis_start,      // vector_select_instr first cycle
	input  wire logic [14:0] vis_pc,         // address of the vector select opcode
	input  wire logic [14:0] next_pc,        // address of instruction about to run
	input  wire logic        return_from_irq_instr_exec,      // return_from_irq_instr executed
	input  wire logic [14:0] pop_addr,       // address popped from stack
	input  wire logic [7:0]  pmem_rdata,     // program memory byte
	output logic             ack_busy,       // acknowledge sequence running
	output logic             push_strobe,    // push return address
	output logic      [14:0] push_addr,      // return address to push
	output logic             pc_load,        // load program counter
	output logic      [14:0] pc_value,       // new program counter
	output logic             pmem_rd,        // program memory read
	output logic      [14:0] pmem_addr,      // program memory address
	output logic             global_irq_enable_o // global enable state
);
	logic [15:0] ev_pulse;
	logic [15:0] pend_r;
	logic [15:0] ena_r;
	logic        global_irq_enable_r;
	logic        trap_pending_flag_r;
	irq_arb_pkg::seq_state_t state_r;
	logic [2:0]  cnt_r;
	logic [7:0]  vec_hi_r;
	logic [15:0] active;
	logic        irq_req;
	logic        a_ph_r;
	logic        a_wr_r;
	logic [11:0] a_off_r;
	logic        ack_busy_r;
	logic        push_r;
	logic [14:0] push_addr_r;
	logic        pc_load_r;
	logic [14:0] pc_value_r;
	logic        pmem_rd_r;
	logic [14:0] pmem_addr_r;
	logic [31:0] hrdata_r;

	irq_event_sync u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ev_async (irq_events),
		.ev_pulse (ev_pulse)
	);

	// ****************************************************
	// helpers
	// ****************************************************
	// highest set slot -> table offset E0..FE
	function automatic logic [7:0] rank_offset(input logic [15:0] act);
		logic [7:0] off;
		off = `IRQ_TBL_BASE;                                // [R20]
		for (int i = 1; i < `IRQ_NSRC; i++) begin
			if (act[i]) off = `IRQ_TBL_BASE + 8'(2 * i);    // [R19] [R6]
		end
		return off;
	endfunction : rank_offset

	// table lies in the block of the opcode, or the next one if opcode is last byte
	function automatic logic [6:0] table_block(input logic [14:0] pc);
		return (pc[7:0] == 8'hFF) ? 7'(pc[14:8] + 7'h01) : pc[14:8]; // [R17]
	endfunction : table_block

	// ****************************************************
	// qualification
	// ****************************************************
	// slot 15 is the trap; its pending bit is the hidden flag
	always_comb begin
		active        = pend_r & ena_r;                    // [R4]
		active[15]    = trap_pending_flag_r;               // [R2]
	end

	// no new acknowledge while a sequence owns the core
	assign irq_req = ~boot_rom_exec & instr_start & ~skip_pending    // [R5] [R15]
		& global_irq_enable_r & ~trap_pending_flag_r & (|active[14:0]) // [R4] [R8] [R13]
		& (state_r == irq_arb_pkg::ST_RUN);

	// ****************************************************
	// ahb-lite slave
	// ****************************************************
	wire a_valid = hsel & htrans[1] & hready;
	wire wr_pend = a_ph_r & a_wr_r & (a_off_r == `IRQ_REG_PEND);
	wire wr_ena  = a_ph_r & a_wr_r & (a_off_r == `IRQ_REG_ENA);
	wire wr_psr  = a_ph_r & a_wr_r & (a_off_r == `IRQ_REG_PSR);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_ph_r  <= 1'b0;
			a_wr_r  <= 1'b0;
			a_off_r <= 12'h000;
		end else begin
			a_ph_r  <= a_valid;
			a_wr_r  <= hwrite;
			a_off_r <= haddr[11:0];
		end
	end

	// reads answer in the data phase straight after the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (a_valid && !hwrite) begin
			case (haddr[11:0])
				`IRQ_REG_PEND: hrdata_r <= {16'h0000, 1'b0, pend_r[14:0]};     // [R3]
				`IRQ_REG_ENA:  hrdata_r <= {16'h0000, 1'b0, ena_r[14:0]};
				`IRQ_REG_PSR:  hrdata_r <= {31'h00000000, global_irq_enable_r};
				`IRQ_REG_STAT: hrdata_r <= {26'h0000000, state_r, ack_busy_r,
					trap_pending_flag_r};
				default:       hrdata_r <= 32'h00000000;
			endcase
		end
	end

	// ****************************************************
	// pending and enable bits
	// ****************************************************
	// event set wins over a software clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r <= `IRQ_RESET_VAL;                      // [R7]
		end else begin
			pend_r <= ((wr_pend ? {1'b0, hwdata[14:0]} : pend_r) | ev_pulse)
				& 16'h7FFF;                                // [R2] [R3] [R14]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ena_r <= `IRQ_RESET_VAL;                       // [R7]
		end else if (wr_ena) begin
			ena_r <= {1'b0, hwdata[14:0]};                 // [R3] [R8]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_irq_enable_r <= 1'b0;                   // [R7]
		end else if (irq_req) begin
			global_irq_enable_r <= 1'b0;                   // [R9]
		end else if (return_from_irq_instr_exec) begin
			global_irq_enable_r <= 1'b1;                   // [R12]
		end else if (wr_psr) begin
			global_irq_enable_r <= hwdata[`IRQ_PSR_GIE_BIT]; // [R11]
		end
	end

	// trap fetch wins over a clear arriving together
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trap_pending_flag_r <= 1'b0;                   // [R7]
		end else if (trap_fetch) begin
			trap_pending_flag_r <= 1'b1;                   // [R22]
		end else if (trap_clear) begin
			trap_pending_flag_r <= 1'b0;                   // [R22]
		end
	end

	// ****************************************************
	// acknowledge and vector select sequencer
	// ****************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= irq_arb_pkg::ST_RUN;
			cnt_r       <= 3'h0;
			vec_hi_r    <= 8'h00;
			ack_busy_r  <= 1'b0;
			push_r      <= 1'b0;
			push_addr_r <= 15'h0000;
			pc_load_r   <= 1'b0;
			pc_value_r  <= 15'h0000;
			pmem_rd_r   <= 1'b0;
			pmem_addr_r <= 15'h0000;
		end else begin
			push_r    <= 1'b0;
			pc_load_r <= 1'b0;
			pmem_rd_r <= 1'b0;
			case (state_r)
				irq_arb_pkg::ST_RUN: begin
					if (irq_req) begin
						state_r     <= irq_arb_pkg::ST_ACK;
						cnt_r       <= 3'h1;
						ack_busy_r  <= 1'b1;
						push_r      <= 1'b1;               // [R9]
						push_addr_r <= next_pc;
					end else if (vis_start) begin
						// sample ranking in the opcode's first cycle
						state_r     <= irq_arb_pkg::ST_VIS;
						pmem_rd_r   <= 1'b1;               // [R16] [R21]
						pmem_addr_r <= {table_block(vis_pc), rank_offset(active)}; // [R21]
					end else if (return_from_irq_instr_exec) begin
						pc_load_r   <= 1'b1;               // [R12]
						pc_value_r  <= pop_addr;
					end
				end
				irq_arb_pkg::ST_ACK: begin
					// hold the core for the last six cycles of the seven-cycle sequence
					cnt_r <= 3'(cnt_r + 3'h1);
					if (cnt_r == `IRQ_ACK_CYCLES - 3'h1) begin // [R10]
						state_r    <= irq_arb_pkg::ST_RUN;
						ack_busy_r <= 1'b0;
						pc_load_r  <= 1'b1;
						pc_value_r <= `IRQ_ENTRY_ADDR;     // [R1] [R9]
					end
				end
				irq_arb_pkg::ST_VIS: begin
					vec_hi_r    <= pmem_rdata;             // [R18]
					state_r     <= irq_arb_pkg::ST_VIS2;
					pmem_rd_r   <= 1'b1;
					pmem_addr_r <= 15'(pmem_addr_r + 15'h0001);
				end
				irq_arb_pkg::ST_VIS2: begin
					state_r    <= irq_arb_pkg::ST_RUN;
					pc_load_r  <= 1'b1;
					pc_value_r <= {vec_hi_r[6:0], pmem_rdata}; // [R18]
				end
				default: state_r <= irq_arb_pkg::ST_RUN;
			endcase
		end
	end

	assign hreadyout           = 1'b1;
	assign hresp               = 1'b0;
	assign hrdata              = hrdata_r;
	assign ack_busy            = ack_busy_r;
	assign push_strobe         = push_r;
	assign push_addr           = push_addr_r;
	assign pc_load             = pc_load_r;
	assign pc_value            = pc_value_r;
	assign pmem_rd             = pmem_rd_r;
	assign pmem_addr           = pmem_addr_r;
	assign global_irq_enable_o = global_irq_enable_r;
endmodule : vectored_interrupt_arbiter
`default_nettype wire
